// File: spsm_defines.vh
`ifndef SPSM_DEFINES_VH
`define SPSM_DEFINES_VH
// register offsets (word address on the plain port)
`define SPSM_ADDR_CTRL 4'h0
`define SPSM_ADDR_CFG 4'h1
`define SPSM_ADDR_STATE 4'h2
`define SPSM_ADDR_IRQ_STS 4'h3
`define SPSM_ADDR_IRQ_MASK 4'h4
`define SPSM_ADDR_WAKE_EN 4'h5
// control register fields
`define SPSM_CTRL_SLEEP_BIT 0
`define SPSM_CTRL_TYPE_LSB 1
`define SPSM_CTRL_TYPE_MSB 2
// sleep type encodings
`define SPSM_SLP_S3 2'h1
`define SPSM_SLP_S4 2'h2
`define SPSM_SLP_S5 2'h3
`define SPSM_SLP_NONE 2'h0
// configuration fields
`define SPSM_CFG_AFTER_LOSS 0
`define SPSM_CFG_LPM_EN0 1
`define SPSM_CFG_LPM_EN1 2
`define SPSM_CFG_DEEP_S4_EN 3
`define SPSM_CFG_DEEP_S5_EN 4
`define SPSM_CFG_RESET 5'h00
`define SPSM_CFG_W 5
// wake enable register
`define SPSM_WAKE_EN_BIT 0
`define SPSM_WAKE_EN_RESET 1'b1
// interrupt status fields
`define SPSM_IRQ_STATE_CHG 0
`define SPSM_IRQ_OVERRIDE 1
`define SPSM_IRQ_PWR_FAIL 2
`define SPSM_IRQ_WAKE_DEFER 3
`define SPSM_IRQ_W 4
// state register field: idle substate bits
`define SPSM_STATE_SUB_LSB 8
// state one-hot codes
`define SPSM_ST_W 10
`define SPSM_ST_S0C0 10'h001
`define SPSM_ST_S0CX 10'h002
`define SPSM_ST_S0I20 10'h004
`define SPSM_ST_S0I21 10'h008
`define SPSM_ST_S3 10'h010
`define SPSM_ST_S4 10'h020
`define SPSM_ST_S5 10'h040
`define SPSM_ST_DS4 10'h080
`define SPSM_ST_DS5 10'h100
`define SPSM_ST_G3 10'h200
// processor idle message codes
`define SPSM_MSG_ACTIVE 2'h0
`define SPSM_MSG_PKG_IDLE 2'h1
`define SPSM_MSG_PKG_DEEP 2'h2
`endif

// File: spsm_power_state.v
`timescale 1ns/100ps
`default_nettype none
`include "spsm_defines.vh"
module spsm_power_state #(
  parameter LTR_W = 10,
  parameter [9:0] LTR_DEEP_MIN = 10'h100,
  parameter [9:0] LTR_GATE_MIN = 10'h040
) (
  // clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output reg [31:0] reg_rdata_out,
  // platform events
  input wire power_good_in,
  input wire override_in,
  input wire wake_event_in,
  input wire ac_supply_present_in,
  input wire low_battery_n_in,
  input wire deep_ok_in,
  // processor idle messages
  input wire idle_msg_valid_in,
  input wire [1:0] idle_msg_code_in,
  input wire [LTR_W-1:0] latency_tol_in,
  // power outputs
  output reg idle_power_gate_n_out,
  output reg main_power_en_out,
  output reg mem_power_en_out,
  output reg wake_logic_en_out,
  output reg full_boot_out,
  output reg irq_out
);

  // state, configuration and event registers
  reg [`SPSM_ST_W-1:0] state_reg, state_next;
  reg [`SPSM_ST_W-1:0] prior_state_reg; // state held before power loss
  reg deep_from_s4_reg;
  reg [4:0] cfg_reg;
  reg [1:0] sleep_type_reg;
  reg sleep_entry_trigger_reg;
  reg wake_en_reg;
  reg wake_pend_reg;
  reg [1:0] pkg_idle_reg;
  reg [`SPSM_IRQ_W-1:0] irq_sts_reg, irq_mask_reg;
  reg [`SPSM_IRQ_W-1:0] irq_set;
  reg [31:0] rdata_next;
  // next values of the output flops and shared strobe decodes
  reg [`SPSM_IRQ_W-1:0] irq_sts_next;
  reg irq_next;
  reg main_power_next;
  reg mem_power_next;
  reg wake_logic_next;
  reg idle_power_gate_n_next;
  reg full_boot_next;
  wire sts_read;
  wire ctrl_write;
  wire next_in_s0;
  wire next_in_idle_gate;
  wire after_power_loss_policy;
  wire low_battery_active;
  wire wake_go;
  wire ovr_to_deep;

  assign after_power_loss_policy = cfg_reg[`SPSM_CFG_AFTER_LOSS];
  assign low_battery_active = ~low_battery_n_in;
  // wakes count only with enable; pending wakes survive a power loss
  assign wake_go = wake_en_reg & (wake_event_in | wake_pend_reg);
  assign ovr_to_deep = cfg_reg[`SPSM_CFG_DEEP_S5_EN] & deep_ok_in;
  // register strobes decoded once: status clear and sleep or boot-flag write
  assign sts_read = reg_read_in & (reg_addr_in == `SPSM_ADDR_IRQ_STS);
  assign ctrl_write = reg_write_in & (reg_addr_in == `SPSM_ADDR_CTRL);
  // working state and its gated substates, judged on the state being entered
  assign next_in_idle_gate = (state_next == `SPSM_ST_S0I20) | (state_next == `SPSM_ST_S0I21);
  assign next_in_s0 = (state_next == `SPSM_ST_S0C0) | (state_next == `SPSM_ST_S0CX) | next_in_idle_gate;

  // next state decode
  always @* begin
    state_next = state_reg;
    if (!power_good_in) begin
      state_next = `SPSM_ST_G3;
    end else begin
      case (state_reg)
        `SPSM_ST_S0C0: begin
          if (override_in) begin
            state_next = ovr_to_deep ? `SPSM_ST_DS5 : `SPSM_ST_S5;
          end else if (sleep_entry_trigger_reg) begin
            case (sleep_type_reg)
              `SPSM_SLP_S3: state_next = `SPSM_ST_S3;
              `SPSM_SLP_S4: state_next = `SPSM_ST_S4;
              `SPSM_SLP_S5: state_next = `SPSM_ST_S5;
              default: state_next = `SPSM_ST_S0C0;
            endcase
          end else if (pkg_idle_reg != `SPSM_MSG_ACTIVE) begin
            state_next = `SPSM_ST_S0CX;
          end
        end
        `SPSM_ST_S0CX, `SPSM_ST_S0I20, `SPSM_ST_S0I21: begin
          if (override_in) begin
            state_next = ovr_to_deep ? `SPSM_ST_DS5 : `SPSM_ST_S5;
          end else if (pkg_idle_reg == `SPSM_MSG_ACTIVE) begin
            state_next = `SPSM_ST_S0C0;
          end else if (pkg_idle_reg == `SPSM_MSG_PKG_DEEP && cfg_reg[`SPSM_CFG_LPM_EN1] &&
                       latency_tol_in >= LTR_DEEP_MIN[LTR_W-1:0]) begin
            state_next = `SPSM_ST_S0I21;
          end else if (cfg_reg[`SPSM_CFG_LPM_EN0] && latency_tol_in >= LTR_GATE_MIN[LTR_W-1:0]) begin
            state_next = `SPSM_ST_S0I20;
          end else begin
            state_next = `SPSM_ST_S0CX;
          end
        end
        `SPSM_ST_S3: begin
          if (wake_go && !low_battery_active) begin
            state_next = `SPSM_ST_S0C0;
          end
        end
        `SPSM_ST_S4: begin
          if (override_in) begin
            state_next = ovr_to_deep ? `SPSM_ST_DS5 : `SPSM_ST_S5;
          end else if (wake_go) begin
            if (!low_battery_active) begin
              state_next = `SPSM_ST_S0C0;
            end
          end else if (cfg_reg[`SPSM_CFG_DEEP_S4_EN] && deep_ok_in) begin
            state_next = `SPSM_ST_DS4;
          end
        end
        `SPSM_ST_S5: begin
          if (wake_go) begin
            if (!low_battery_active) begin
              state_next = `SPSM_ST_S0C0;
            end
          end else if (cfg_reg[`SPSM_CFG_DEEP_S5_EN] && deep_ok_in) begin
            state_next = `SPSM_ST_DS5;
          end
        end
        `SPSM_ST_DS4, `SPSM_ST_DS5: begin
          if (override_in) begin
            state_next = `SPSM_ST_S5;
          end else if (wake_go) begin
            if (!low_battery_active) begin
              state_next = `SPSM_ST_S0C0;
            end
          end else if (ac_supply_present_in) begin
            state_next = deep_from_s4_reg ? `SPSM_ST_S4 : `SPSM_ST_S5;
          end
        end
        `SPSM_ST_G3: begin
          // power is good again: pick from prior state and policy
          if (low_battery_active) begin
            state_next = (prior_state_reg == `SPSM_ST_S4) ? `SPSM_ST_S4 : `SPSM_ST_S5;
          end else if (!after_power_loss_policy) begin
            state_next = `SPSM_ST_S0C0;
          end else if (prior_state_reg == `SPSM_ST_S4) begin
            state_next = `SPSM_ST_S4;
          end else begin
            state_next = `SPSM_ST_S5;
          end
        end
        default: state_next = `SPSM_ST_S5;
      endcase
    end
  end

  // interrupt events
  always @* begin
    irq_set = {`SPSM_IRQ_W{1'b0}};
    irq_set[`SPSM_IRQ_STATE_CHG] = (state_next != state_reg);
    irq_set[`SPSM_IRQ_OVERRIDE] = override_in & (state_next != state_reg) & (state_next != `SPSM_ST_G3);
    irq_set[`SPSM_IRQ_PWR_FAIL] = (state_next == `SPSM_ST_G3) & (state_reg != `SPSM_ST_G3);
    irq_set[`SPSM_IRQ_WAKE_DEFER] = wake_go & low_battery_active & (state_next == state_reg) &
                                    (state_reg != `SPSM_ST_G3);
  end

  // sticky status next value: an event in the clearing read cycle survives it
  always @* begin
    if (sts_read) begin
      irq_sts_next = irq_set;
    end else begin
      irq_sts_next = irq_sts_reg | irq_set;
    end
    // the level output tracks the status about to be held, so a clear drops it at once
    irq_next = |(irq_sts_next & irq_mask_reg);
  end

  // power plane controls, taken from the state being entered
  always @* begin
    main_power_next = next_in_s0;
    // memory keeps its context in S3 besides the working state
    mem_power_next = next_in_s0 | (state_next == `SPSM_ST_S3);
    // only mechanical off drops the wake-detect well
    wake_logic_next = (state_next != `SPSM_ST_G3);
    // the idle gate drops only in the two gated substates
    idle_power_gate_n_next = ~next_in_idle_gate;
    // a boot from soft off or mechanical off wins over a clearing write
    full_boot_next = full_boot_out;
    if (state_next == `SPSM_ST_S0C0 && (state_reg == `SPSM_ST_S5 || state_reg == `SPSM_ST_G3)) begin
      full_boot_next = 1'b1;
    end else if (ctrl_write) begin
      full_boot_next = 1'b0;
    end
  end

  // read mux
  always @* begin
    rdata_next = 32'h00000000;
    case (reg_addr_in)
      `SPSM_ADDR_CTRL: rdata_next[`SPSM_CTRL_TYPE_MSB:`SPSM_CTRL_TYPE_LSB] = sleep_type_reg;
      `SPSM_ADDR_CFG: rdata_next[`SPSM_CFG_W-1:0] = cfg_reg;
      `SPSM_ADDR_STATE: begin
        rdata_next[`SPSM_ST_W-1:0] = state_reg;
        rdata_next[`SPSM_ST_W+1:`SPSM_ST_W] = pkg_idle_reg;
      end
      `SPSM_ADDR_IRQ_STS: rdata_next[`SPSM_IRQ_W-1:0] = irq_sts_reg;
      `SPSM_ADDR_IRQ_MASK: rdata_next[`SPSM_IRQ_W-1:0] = irq_mask_reg;
      `SPSM_ADDR_WAKE_EN: rdata_next[`SPSM_WAKE_EN_BIT] = wake_en_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // state register and the memory of where sleep and power loss came from
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      state_reg <= `SPSM_ST_S5;
      prior_state_reg <= `SPSM_ST_S5;
      deep_from_s4_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // remember which deep state was entered, so its resume path returns to S4 from DS4 and to S5 from DS5
      if (state_next == `SPSM_ST_DS4 && state_reg != `SPSM_ST_DS4) begin
        deep_from_s4_reg <= 1'b1;
      end else if (state_next == `SPSM_ST_DS5 && state_reg != `SPSM_ST_DS5) begin
        deep_from_s4_reg <= 1'b0;
      end
      // capture the state held on entry to mechanical off
      if (state_next == `SPSM_ST_G3 && state_reg != `SPSM_ST_G3) begin
        prior_state_reg <= state_reg;
      end
    end
  end

  // software registers; the sleep trigger is a one-cycle pulse
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      cfg_reg <= `SPSM_CFG_RESET;
      sleep_type_reg <= `SPSM_SLP_NONE;
      sleep_entry_trigger_reg <= 1'b0;
      irq_mask_reg <= {`SPSM_IRQ_W{1'b0}};
      wake_en_reg <= `SPSM_WAKE_EN_RESET;
    end else begin
      // sleep trigger self-clears after one cycle, whether acted on or not
      sleep_entry_trigger_reg <= 1'b0;
      if (ctrl_write) begin
        sleep_type_reg <= reg_wdata_in[`SPSM_CTRL_TYPE_MSB:`SPSM_CTRL_TYPE_LSB];
        // a sleep request outside full on is dropped, not held for later
        sleep_entry_trigger_reg <= reg_wdata_in[`SPSM_CTRL_SLEEP_BIT] & (state_reg == `SPSM_ST_S0C0);
      end
      // configuration: after-loss policy, substate and deep sleep enables
      if (reg_write_in && reg_addr_in == `SPSM_ADDR_CFG) begin
        cfg_reg <= reg_wdata_in[`SPSM_CFG_W-1:0];
      end
      // mask and wake enable are plain read-write bits
      if (reg_write_in && reg_addr_in == `SPSM_ADDR_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata_in[`SPSM_IRQ_W-1:0];
      end
      if (reg_write_in && reg_addr_in == `SPSM_ADDR_WAKE_EN) begin
        wake_en_reg <= reg_wdata_in[`SPSM_WAKE_EN_BIT];
      end
    end
  end

  // processor idle depth and the pending wake
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      pkg_idle_reg <= `SPSM_MSG_ACTIVE;
      wake_pend_reg <= 1'b0;
    end else begin
      // idle messages are the only source of processor idle depth
      if (idle_msg_valid_in) begin
        pkg_idle_reg <= idle_msg_code_in;
      end
      // pending wake: held through power loss, cleared once consumed
      if (state_reg == `SPSM_ST_G3) begin
        wake_pend_reg <= wake_pend_reg;
      end else if (state_next == `SPSM_ST_S0C0 && state_reg != `SPSM_ST_S0C0) begin
        wake_pend_reg <= 1'b0;
      end else if (wake_event_in && wake_en_reg) begin
        wake_pend_reg <= 1'b1;
      end
    end
  end

  // sticky interrupt status; a read clears, an event of the same cycle is kept
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      irq_sts_reg <= {`SPSM_IRQ_W{1'b0}};
    end else begin
      irq_sts_reg <= irq_sts_next;
    end
  end

  // output flops: every port leaves the block straight from a register
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h00000000;
      idle_power_gate_n_out <= 1'b1;
      main_power_en_out <= 1'b0;
      mem_power_en_out <= 1'b0;
      wake_logic_en_out <= 1'b1;
      full_boot_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      // read data stand for the one cycle after the strobe, zero otherwise
      reg_rdata_out <= reg_read_in ? rdata_next : 32'h00000000;
      // power planes move on the same edge as the state register
      main_power_en_out <= main_power_next;
      mem_power_en_out <= mem_power_next;
      wake_logic_en_out <= wake_logic_next;
      idle_power_gate_n_out <= idle_power_gate_n_next;
      full_boot_out <= full_boot_next;
      // interrupt level mirrors the status held from this edge on
      irq_out <= irq_next;
    end
  end

endmodule
`default_nettype wire

// File: spsm_power_state_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module spsm_power_state_assertions (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // inputs watched
  input wire logic reg_read_in,
  input wire logic power_good_in,
  input wire logic override_in,
  input wire logic low_battery_n_in,
  // outputs watched
  input wire logic [31:0] reg_rdata_out,
  input wire logic idle_power_gate_n_out,
  input wire logic main_power_en_out,
  input wire logic mem_power_en_out,
  input wire logic wake_logic_en_out,
  input wire logic full_boot_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  // supply lost, then every plane dark
  sequence s_loss;
    $fell(power_good_in);
  endsequence
  sequence s_dark;
    !wake_logic_en_out && !main_power_en_out && !mem_power_en_out;
  endsequence
  // read data only stand in the cycle after a read strobe
  a_rdata_rest_zero: assert property (!reg_read_in |=> reg_rdata_out == 32'h0)
    else $error("read data not zero outside a read");
  a_loss_goes_dark: assert property (s_loss |-> ##[1:2] s_dark)
    else $error("planes still on after power loss");
  a_dark_holds_off: assert property (!power_good_in && !wake_logic_en_out |=> s_dark)
    else $error("mechanical off left while supply absent");
  a_lowbat_defers_on: assert property (!low_battery_n_in && !main_power_en_out |=> !main_power_en_out)
    else $error("full on entered during low battery");
  a_override_leaves_on: assert property (override_in && main_power_en_out |=> !main_power_en_out)
    else $error("override did not leave full on");
  a_gate_only_s0: assert property (!idle_power_gate_n_out |-> main_power_en_out && mem_power_en_out)
    else $error("idle gate low outside working state");
  a_boot_with_on: assert property ($rose(full_boot_out) |-> ##[0:1] main_power_en_out)
    else $error("full boot flag without full on");
  a_main_keeps_mem: assert property (main_power_en_out |-> mem_power_en_out)
    else $error("main power on with memory off");
endmodule
`default_nettype wire

// File: spsm_platform_model.sv
`timescale 1ns/100ps
`default_nettype none
module spsm_platform_model (
  // clock
  input wire logic clk_sys_in,
  // platform levels
  output var logic supply_good_out,
  output var logic override_out,
  output var logic wake_out,
  output var logic ac_out,
  output var logic low_bat_n_out,
  output var logic deep_ok_out,
  // processor idle messages
  output var logic msg_valid_out,
  output var logic [1:0] msg_code_out,
  output var logic [9:0] latency_tol_out
);
  // supply good, battery fine, no message
  initial begin
    {supply_good_out, override_out, wake_out, ac_out, low_bat_n_out, deep_ok_out} = 6'b100010;
    msg_valid_out = 1'b0;
    msg_code_out = 2'h3;
    latency_tol_out = 10'h0;
  end
  // levels change just after an edge; the battery level is ours to drive
  task automatic lines(input logic [5:0] v);
    @(posedge clk_sys_in);
    {supply_good_out, override_out, wake_out, ac_out, low_bat_n_out, deep_ok_out} <= v;
  endtask
  // one message strobe; the code line is scrambled once released
  task automatic msg(input logic [1:0] c, input logic [9:0] l);
    @(posedge clk_sys_in);
    msg_valid_out <= 1'b1;
    msg_code_out <= c;
    latency_tol_out <= l;
    @(posedge clk_sys_in);
    msg_valid_out <= 1'b0;
    msg_code_out <= ~c;
  endtask
endmodule
`default_nettype wire

// File: spsm_power_state_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "spsm_defines.vh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module spsm_power_state_tb;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  wire [31:0] reg_rdata_out;
  wire power_good_in, override_in, wake_event_in, ac_supply_present_in, low_battery_n_in, deep_ok_in;
  wire idle_msg_valid_in, idle_power_gate_n_out, main_power_en_out, mem_power_en_out;
  wire wake_logic_en_out, full_boot_out, irq_out;
  wire [1:0] idle_msg_code_in;
  wire [9:0] latency_tol_in;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int t;
  // clock
  always #2 clk_sys_in = ~clk_sys_in;
  spsm_platform_model p (.clk_sys_in(clk_sys_in), .supply_good_out(power_good_in), .override_out(override_in),
    .wake_out(wake_event_in), .ac_out(ac_supply_present_in), .low_bat_n_out(low_battery_n_in),
    .deep_ok_out(deep_ok_in), .msg_valid_out(idle_msg_valid_in), .msg_code_out(idle_msg_code_in),
    .latency_tol_out(latency_tol_in));
  spsm_power_state dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .power_good_in(power_good_in), .override_in(override_in),
    .wake_event_in(wake_event_in), .ac_supply_present_in(ac_supply_present_in),
    .low_battery_n_in(low_battery_n_in), .deep_ok_in(deep_ok_in), .idle_msg_valid_in(idle_msg_valid_in),
    .idle_msg_code_in(idle_msg_code_in), .latency_tol_in(latency_tol_in),
    .idle_power_gate_n_out(idle_power_gate_n_out), .main_power_en_out(main_power_en_out),
    .mem_power_en_out(mem_power_en_out), .wake_logic_en_out(wake_logic_en_out),
    .full_boot_out(full_boot_out), .irq_out(irq_out));
  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
    #1 `CHK(reg_rdata_out, e)
  endtask
  // let a move settle, then compare the state word
  task automatic chs(input logic [1:0] c, input logic [9:0] s);
    repeat (3) @(posedge clk_sys_in);
    rd(`SPSM_ADDR_STATE, {20'h0, c, s});
  endtask
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rd(`SPSM_ADDR_CFG, 32'h0);
    rd(`SPSM_ADDR_WAKE_EN, 32'h1);
    rd(4'hf, 32'h0);
    chs(2'h0, `SPSM_ST_S5);
    // wake held off by low battery, then a full boot
    wr(`SPSM_ADDR_IRQ_MASK, 32'hf);
    p.lines(6'b101000);
    p.lines(6'b100000);
    chs(2'h0, `SPSM_ST_S5);
    p.lines(6'b100010);
    chs(2'h0, `SPSM_ST_S0C0);
    `CHK(full_boot_out, 1'b1)
    `CHK(irq_out, 1'b1)
    rd(`SPSM_ADDR_IRQ_STS, 32'h9);
    #9 `CHK(irq_out, 1'b0)
    wr(`SPSM_ADDR_IRQ_MASK, 32'h0);
    // every sleep type from full on, woken each time
    for (t = 1; t < 4; t++) begin
      wr(`SPSM_ADDR_CTRL, 32'(t * 2 + 1));
      chs(2'h0, 10'h008 << t);
      `CHK(mem_power_en_out, t == 1)
      `CHK(main_power_en_out, 1'b0)
      p.lines(6'b101010);
      p.lines(6'b100010);
      chs(2'h0, `SPSM_ST_S0C0);
    end
    `CHK(irq_out, 1'b0)
    rd(`SPSM_ADDR_IRQ_STS, 32'h1);
    // idle substates from message depth and latency tolerance
    wr(`SPSM_ADDR_CFG, 32'h6);
    p.msg(2'h1, 10'h03f);
    p.msg(2'h1, 10'h03f);
    chs(2'h1, `SPSM_ST_S0CX);
    p.msg(2'h2, 10'h100);
    chs(2'h2, `SPSM_ST_S0I21);
    `CHK(idle_power_gate_n_out, 1'b0)
    p.msg(2'h0, 10'h0);
    chs(2'h0, `SPSM_ST_S0C0);
    `CHK(idle_power_gate_n_out, 1'b1)
    p.msg(2'h1, 10'h040);
    p.msg(2'h1, 10'h040);
    chs(2'h1, `SPSM_ST_S0I20);
    p.msg(2'h0, 10'h0);
    wr(`SPSM_ADDR_CFG, 32'h0);
    p.msg(2'h2, 10'h3ff);
    p.msg(2'h2, 10'h3ff);
    chs(2'h2, `SPSM_ST_S0CX);
    p.msg(2'h0, 10'h0);
    // override into deep soft off, supply present back out
    wr(`SPSM_ADDR_CFG, 32'h18);
    p.lines(6'b110011);
    p.lines(6'b100011);
    chs(2'h0, `SPSM_ST_DS5);
    `CHK(mem_power_en_out, 1'b0)
    `CHK(wake_logic_en_out, 1'b1)
    p.lines(6'b100110);
    chs(2'h0, `SPSM_ST_S5);
    p.lines(6'b101010);
    p.lines(6'b100010);
    wr(`SPSM_ADDR_CTRL, 32'h5);
    p.lines(6'b100011);
    chs(2'h0, `SPSM_ST_DS4);
    p.lines(6'b100110);
    chs(2'h0, `SPSM_ST_S4);
    p.lines(6'b100011);
    chs(2'h0, `SPSM_ST_DS4);
    p.lines(6'b101010);
    p.lines(6'b100010);
    chs(2'h0, `SPSM_ST_S0C0);
    // supply lost and returned under both policies
    wr(`SPSM_ADDR_CTRL, 32'h5);
    wr(`SPSM_ADDR_CFG, 32'h1);
    p.lines(6'b000010);
    chs(2'h0, `SPSM_ST_G3);
    `CHK(wake_logic_en_out, 1'b0)
    p.lines(6'b100010);
    chs(2'h0, `SPSM_ST_S4);
    p.lines(6'b101000);
    p.lines(6'b000000);
    p.lines(6'b100000);
    chs(2'h0, `SPSM_ST_S4);
    p.lines(6'b100010);
    chs(2'h0, `SPSM_ST_S0C0);
    wr(`SPSM_ADDR_CFG, 32'h0);
    wr(`SPSM_ADDR_CTRL, 32'h0);
    p.lines(6'b000010);
    p.lines(6'b100010);
    chs(2'h0, `SPSM_ST_S0C0);
    `CHK(full_boot_out, 1'b1)
    stop_test();
  end
endmodule
bind spsm_power_state spsm_power_state_assertions chk (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .reg_read_in(reg_read_in), .power_good_in(power_good_in), .override_in(override_in),
  .low_battery_n_in(low_battery_n_in), .reg_rdata_out(reg_rdata_out), .idle_power_gate_n_out(idle_power_gate_n_out),
  .main_power_en_out(main_power_en_out), .mem_power_en_out(mem_power_en_out),
  .wake_logic_en_out(wake_logic_en_out), .full_boot_out(full_boot_out));
`default_nettype wire
